// ===== rtl/gauge_cfg_pkg.sv
// shared constants and carriers for the gauge configuration decoder
package gauge_cfg_pkg;
  // register offsets (data-flash addresses, used as register indices)
  localparam logic [7:0] OFS_TIME_ALARM   = 8'h00;
  localparam logic [7:0] OFS_CAP_ALARM    = 8'h02;
  localparam logic [7:0] OFS_NOM_VOLT     = 8'h04;
  localparam logic [7:0] OFS_INIT_CYCLE   = 8'h0C;
  localparam logic [7:0] OFS_PACK_OPT     = 8'h28;
  localparam logic [7:0] OFS_GAUGE_OPT    = 8'h29;
  localparam logic [7:0] OFS_MISC_HIGH    = 8'h2A;
  localparam logic [7:0] OFS_FILTER       = 8'h2C;
  localparam logic [7:0] OFS_RATED_CAP    = 8'h32;
  localparam logic [7:0] OFS_LEARNED_CAP  = 8'h36;
  localparam logic [7:0] OFS_CYCLE_THR    = 8'h37;
  localparam logic [7:0] OFS_EFFICIENCY   = 8'h54;
  localparam logic [7:0] OFS_SHUNT_GAIN   = 8'hCB;
  localparam logic [7:0] OFS_GAIN_LO      = 8'hCD;
  localparam logic [7:0] OFS_GAIN_HI      = 8'hCE;
  localparam logic [7:0] OFS_COUNTER_OFFSET    = 8'hD2;
  localparam logic [7:0] OFS_GND_OFFSET   = 8'hD4;
  localparam logic [7:0] OFS_ADC_OFFSET   = 8'hD5;
  // own registers: control, status, results
  localparam logic [7:0] OFS_CTRL         = 8'hE0;
  localparam logic [7:0] OFS_STATUS       = 8'hE1;
  localparam logic [7:0] OFS_CYCLE_COUNT  = 8'hE2;
  localparam logic [7:0] OFS_DESIGN_CAP   = 8'hE3;
  localparam logic [7:0] OFS_REMAIN_CAP   = 8'hE4;
  localparam logic [7:0] OFS_TERM_PCT     = 8'hE5;
  localparam logic [7:0] OFS_FILT_NV_LO   = 8'hE6;
  localparam logic [7:0] OFS_FILT_NV_HI   = 8'hE7;
  // field positions
  localparam int PK_LED_SRC    = 7;
  localparam int PK_LED_CNT    = 5;
  localparam int PK_HOST_PEC   = 4;
  localparam int PK_CHG_PEC    = 3;
  localparam int PK_BC_DIS     = 2;
  localparam int PK_CELLS      = 0;
  localparam int GA_TERM_SYNC  = 6;
  localparam int GA_INDEP_CHG  = 5;
  localparam int GA_EDV_COMP   = 4;
  localparam int GA_EDV_SRC    = 3;
  localparam int GA_OV_SRC     = 2;
  localparam int GA_CONTINUOUS_MIDRANGE_CORRECTION       = 1;
  localparam int GA_SINGLE_MIDRANGE_CORRECTION       = 0;
  localparam int MH_INT_TEMP   = 7;
  localparam int MH_FE_CHECK   = 5;
  localparam int MH_SLEEP_DIS  = 4;
  localparam int MH_OT_DSG     = 3;
  localparam int CT_CAP_POWER  = 0;
  localparam int CT_FE_PF_EN   = 1;
  // reset values
  localparam logic [7:0]  RST_PACK_OPT  = 8'h63;
  localparam logic [7:0]  RST_GAUGE_OPT = 8'h40;
  localparam logic [7:0]  RST_MISC_HIGH = 8'h02;
  localparam logic [7:0]  RST_EFFIC     = 8'hFF;
  localparam logic [7:0]  RST_TERM_PCT  = 8'h64;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  // timing
  localparam int CLK_HZ        = 20_000_000;
  localparam int SLEEP_IDLE_S  = 2;
  localparam int SLEEP_CYCLES  = CLK_HZ * SLEEP_IDLE_S;
  localparam int FILTER_STEP_NV = 290;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic        led_relative;
    logic [2:0]  led_segments;
    logic        host_pec;
    logic        charger_pec;
    logic        host_bcast_en;
    logic        charger_bcast_en;
    logic [2:0]  cell_count;
    logic        edv_comp;
    logic        edv_from_pack;
    logic        indep_learning;
    logic        continuous_midrange_correction_enable;
    logic        ov_from_cells;
    logic        int_temp;
    logic        fe_check;
    logic        fe_pf_enable;
    logic        charge_fet_off;
    logic        discharge_fet_off;
  } gauge_ctrl_t;

  typedef struct packed {
    logic [15:0] counter_offset;
    logic [7:0]  gnd_offset;
    logic [7:0]  adc_offset;
  } offset_set_t;
endpackage

// ===== rtl/sleep_idle_timer.sv
// bus-idle timer: requests sleep after the bus stays low long enough
`timescale 1ns/10ps
module sleep_idle_timer #(
  parameter int IDLE_CYCLES = gauge_cfg_pkg::SLEEP_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic bus_low,
  input  wire logic disable_sleep,
  output logic      sleep_due
);
  if (IDLE_CYCLES < 1) begin : g_idle_check
    $error("IDLE_CYCLES must be positive");
  end

  typedef struct packed {
    logic [31:0] count;
    logic        due;
  } idle_state_t;

  idle_state_t s_q;
  idle_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!bus_low || disable_sleep) begin
      s_d.count = 32'h00000000;
      s_d.due   = 1'b0;
    end else if (s_q.count >= 32'(IDLE_CYCLES - 1)) begin
      s_d.due = 1'b1;
    end else begin
      s_d.count = s_q.count + 32'h00000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sleep_due = s_q.due;
endmodule

// ===== rtl/gauge_config_decode.sv
// gas-gauge configuration register bank and decoder
// Function
// - converter result times shunt gain, then 32-bit counter gain, gives charge.
// - offsets refreshed once sleep conditions met, in the cycle sleep is entered.
// - filter threshold volts equals filter byte times 290 nV.
// - design capacity as stored, or times pack voltage in 10 mWh.
// - time and capacity alarms are thresholds for commands 0x01, 0x02.
// - cycle count rises each time discharge reaches the threshold in mAh.
// - added charge weighted by efficiency code, percent times 2.56 minus one.
// - led source absolute charge when bit clear, relative when set.
// - segment field 00/11 five, 01 three, 10 four.
// - PEC appended to host alarms and charger broadcasts per their bits.
// - broadcast disable suppresses all broadcasts; mode writes cannot undo.
// - cell field 11 four, 10 three, 01 two cells.
// - termination sync sets remaining capacity to percent of full capacity.
// - learning optimised for independent charger when set, smart otherwise.
// - end-of-discharge thresholds computed when set, fixed values when clear.
// - end-of-discharge judged on pack voltage when set, lowest cell otherwise.
// - overvoltage on highest cell times count when set, pack voltage otherwise.
// - continuous midrange correction bit, and one-shot correction after reset.
// - sleep after bus low 2 s unless sleep disable set.
// - overtemp always cuts charge FET, discharge FET only when bit set.
// - front-end link check; permanent fail only with control register bit 1.
// - internal temperature sensor when set, external thermistor when clear.
`timescale 1ns/10ps
module gauge_config_decode #(
  parameter int SLEEP_IDLE_CYCLES = gauge_cfg_pkg::SLEEP_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire gauge_cfg_pkg::reg_req_t    req,
  output logic [15:0]                     rdata,
  input  wire logic                       smbus_clk_pin,
  input  wire logic                       smbus_data_pin,
  input  wire logic [15:0]                conv_result,
  input  wire logic                       conv_valid,
  input  wire logic                       conv_discharge,
  input  wire logic                       charge_term,
  input  wire logic                       overtemp,
  input  wire logic                       fe_link_error,
  input  wire logic                       mode_bcast_request,
  input  wire gauge_cfg_pkg::offset_set_t cal_offsets,
  output gauge_cfg_pkg::gauge_ctrl_t      ctrl,
  output logic [31:0]                     charge_delta,
  output logic                            charge_delta_valid,
  output logic                            sleep_now,
  output logic                            midrange_once,
  output logic                            fe_perm_fail
);
  if (SLEEP_IDLE_CYCLES < 1) begin : g_idle_check
    $error("SLEEP_IDLE_CYCLES must be positive");
  end

  typedef struct packed {
    logic [15:0] time_alarm;
    logic [15:0] cap_alarm;
    logic [15:0] nom_volt;
    logic [15:0] init_cycle;
    logic [7:0]  pack_opt;
    logic [7:0]  gauge_opt;
    logic [7:0]  misc_high;
    logic [7:0]  filter;
    logic [15:0] rated_cap;
    logic [15:0] learned_cap;
    logic [15:0] cycle_thr;
    logic [7:0]  effic;
    logic [15:0] shunt_gain;
    logic [31:0] gain_factor;
    logic [15:0] counter_offset;
    logic [7:0]  gnd_offset;
    logic [7:0]  adc_offset;
    logic [7:0]  ctl;
    logic [7:0]  term_pct;
    logic [15:0] cycle_count;
    logic [15:0] dsg_accum;
    logic [15:0] remain_cap;
    logic [15:0] rdata;
    logic [31:0] delta;
    logic        delta_valid;
    logic        sleeping;
    logic        once_done;
    logic        once_pulse;
    logic        fe_fail;
    gauge_cfg_pkg::gauge_ctrl_t ctrl;
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
  } bank_t;

  bank_t s_q;
  bank_t s_d;
  logic  sleep_due;

  function automatic logic [2:0] led_count(input logic [1:0] f);
    case (f)
      2'b01:   led_count = 3'h3;
      2'b10:   led_count = 3'h4;
      default: led_count = 3'h5;
    endcase
  endfunction

  function automatic logic [2:0] cell_count(input logic [1:0] f);
    case (f)
      2'b11:   cell_count = 3'h4;
      2'b10:   cell_count = 3'h3;
      2'b01:   cell_count = 3'h2;
      default: cell_count = 3'h0; // undefined encoding
    endcase
  endfunction

  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[16] ? 16'hFFFF : s[15:0];
  endfunction

  logic bus_low;
  assign bus_low = !s_q.scl_sync[1] && !s_q.sda_sync[1];

  sleep_idle_timer #(
    .IDLE_CYCLES (SLEEP_IDLE_CYCLES)
  ) u_idle (
    .clk           (clk),
    .rst           (rst),
    .bus_low       (bus_low),
    .disable_sleep (s_q.misc_high[gauge_cfg_pkg::MH_SLEEP_DIS]),
    .sleep_due     (sleep_due)
  );

  logic [31:0] scaled;
  logic [63:0] gained;
  logic [47:0] weighted;
  logic [31:0] dcap_power;
  logic [31:0] filt_nv;
  logic [23:0] term_cap;
  always_comb begin
    scaled     = conv_result * s_q.shunt_gain;
    gained     = scaled * s_q.gain_factor;
    weighted   = 48'(gained[47:16]) * 48'({8'h00, s_q.effic} + 16'h0001);
    dcap_power = s_q.rated_cap * s_q.nom_volt;
    filt_nv    = 32'(s_q.filter) * 32'(gauge_cfg_pkg::FILTER_STEP_NV);
    term_cap   = s_q.learned_cap * s_q.term_pct;
  end

  logic [15:0] design_cap;
  always_comb begin
    if (s_q.ctl[gauge_cfg_pkg::CT_CAP_POWER]) begin
      // mAh times mV is uWh; 10 mWh is 10000 of them
      design_cap = 16'(dcap_power / 32'h0000_2710);
    end else begin
      design_cap = s_q.rated_cap;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.scl_sync    = {s_q.scl_sync[0], smbus_clk_pin};
    s_d.sda_sync    = {s_q.sda_sync[0], smbus_data_pin};
    s_d.delta_valid = 1'b0;
    s_d.once_pulse  = 1'b0;
    s_d.rdata       = 16'h0000;

    if (req.wr) begin
      case (req.addr)
        gauge_cfg_pkg::OFS_TIME_ALARM:  s_d.time_alarm = req.wdata;
        gauge_cfg_pkg::OFS_CAP_ALARM:   s_d.cap_alarm  = req.wdata;
        gauge_cfg_pkg::OFS_NOM_VOLT:    s_d.nom_volt   = req.wdata;
        gauge_cfg_pkg::OFS_INIT_CYCLE: begin
          s_d.init_cycle  = req.wdata;
          s_d.cycle_count = req.wdata;
        end
        gauge_cfg_pkg::OFS_PACK_OPT:    s_d.pack_opt   = req.wdata[7:0];
        gauge_cfg_pkg::OFS_GAUGE_OPT:   s_d.gauge_opt  = req.wdata[7:0];
        gauge_cfg_pkg::OFS_MISC_HIGH:   s_d.misc_high  = req.wdata[7:0];
        gauge_cfg_pkg::OFS_FILTER:      s_d.filter     = req.wdata[7:0];
        gauge_cfg_pkg::OFS_RATED_CAP:   s_d.rated_cap  = req.wdata;
        gauge_cfg_pkg::OFS_LEARNED_CAP: s_d.learned_cap = req.wdata;
        gauge_cfg_pkg::OFS_CYCLE_THR:   s_d.cycle_thr  = req.wdata;
        gauge_cfg_pkg::OFS_EFFICIENCY:  s_d.effic      = req.wdata[7:0];
        gauge_cfg_pkg::OFS_SHUNT_GAIN:  s_d.shunt_gain = req.wdata;
        gauge_cfg_pkg::OFS_GAIN_LO: s_d.gain_factor[15:0]  = req.wdata;
        gauge_cfg_pkg::OFS_GAIN_HI: s_d.gain_factor[31:16] = req.wdata;
        gauge_cfg_pkg::OFS_COUNTER_OFFSET:   s_d.counter_offset  = req.wdata;
        gauge_cfg_pkg::OFS_GND_OFFSET:  s_d.gnd_offset = req.wdata[7:0];
        gauge_cfg_pkg::OFS_ADC_OFFSET:  s_d.adc_offset = req.wdata[7:0];
        gauge_cfg_pkg::OFS_CTRL:        s_d.ctl        = req.wdata[7:0];
        gauge_cfg_pkg::OFS_REMAIN_CAP:  s_d.remain_cap = req.wdata;
        gauge_cfg_pkg::OFS_TERM_PCT:    s_d.term_pct   = req.wdata[7:0];
        default: ;
      endcase
    end

    if (req.rd) begin
      case (req.addr)
        gauge_cfg_pkg::OFS_TIME_ALARM:  s_d.rdata = s_q.time_alarm;
        gauge_cfg_pkg::OFS_CAP_ALARM:   s_d.rdata = s_q.cap_alarm;
        gauge_cfg_pkg::OFS_NOM_VOLT:    s_d.rdata = s_q.nom_volt;
        gauge_cfg_pkg::OFS_INIT_CYCLE:  s_d.rdata = s_q.init_cycle;
        gauge_cfg_pkg::OFS_PACK_OPT:    s_d.rdata = {8'h00, s_q.pack_opt};
        gauge_cfg_pkg::OFS_GAUGE_OPT:   s_d.rdata = {8'h00, s_q.gauge_opt};
        gauge_cfg_pkg::OFS_MISC_HIGH:   s_d.rdata = {8'h00, s_q.misc_high};
        gauge_cfg_pkg::OFS_FILTER:      s_d.rdata = {8'h00, s_q.filter};
        gauge_cfg_pkg::OFS_RATED_CAP:   s_d.rdata = s_q.rated_cap;
        gauge_cfg_pkg::OFS_LEARNED_CAP: s_d.rdata = s_q.learned_cap;
        gauge_cfg_pkg::OFS_CYCLE_THR:   s_d.rdata = s_q.cycle_thr;
        gauge_cfg_pkg::OFS_EFFICIENCY:  s_d.rdata = {8'h00, s_q.effic};
        gauge_cfg_pkg::OFS_SHUNT_GAIN:  s_d.rdata = s_q.shunt_gain;
        gauge_cfg_pkg::OFS_GAIN_LO: s_d.rdata = s_q.gain_factor[15:0];
        gauge_cfg_pkg::OFS_GAIN_HI: s_d.rdata = s_q.gain_factor[31:16];
        gauge_cfg_pkg::OFS_COUNTER_OFFSET:   s_d.rdata = s_q.counter_offset;
        gauge_cfg_pkg::OFS_GND_OFFSET:  s_d.rdata = {8'h00, s_q.gnd_offset};
        gauge_cfg_pkg::OFS_ADC_OFFSET:  s_d.rdata = {8'h00, s_q.adc_offset};
        gauge_cfg_pkg::OFS_CTRL:        s_d.rdata = {8'h00, s_q.ctl};
        gauge_cfg_pkg::OFS_STATUS:
          s_d.rdata = {11'h000, s_q.fe_fail, s_q.once_done,
                       s_q.sleeping, s_q.ctrl.charge_fet_off,
                       s_q.ctrl.discharge_fet_off};
        gauge_cfg_pkg::OFS_CYCLE_COUNT: s_d.rdata = s_q.cycle_count;
        gauge_cfg_pkg::OFS_DESIGN_CAP:  s_d.rdata = design_cap;
        gauge_cfg_pkg::OFS_REMAIN_CAP:  s_d.rdata = s_q.remain_cap;
        gauge_cfg_pkg::OFS_TERM_PCT:    s_d.rdata = {8'h00, s_q.term_pct};
        gauge_cfg_pkg::OFS_FILT_NV_LO:  s_d.rdata = filt_nv[15:0];
        gauge_cfg_pkg::OFS_FILT_NV_HI:  s_d.rdata = filt_nv[31:16];
        default:                        s_d.rdata = 16'h0000;
      endcase
    end

    // charge flow: scale, weight charging, count discharge toward cycles
    if (conv_valid && !s_q.sleeping) begin
      s_d.delta_valid = 1'b1;
      if (conv_discharge) begin
        s_d.delta = gained[47:16];
        if (sat_add(s_q.dsg_accum, gained[31:16]) >= s_q.cycle_thr &&
            s_q.cycle_thr != 16'h0000) begin
          s_d.dsg_accum   = 16'h0000;
          s_d.cycle_count = s_q.cycle_count + 16'h0001;
        end else begin
          s_d.dsg_accum = sat_add(s_q.dsg_accum, gained[31:16]);
        end
      end else begin
        s_d.delta = weighted[39:8];
      end
    end

    // termination capacity sync
    if (charge_term && s_q.gauge_opt[gauge_cfg_pkg::GA_TERM_SYNC]) begin
      s_d.remain_cap = 16'(term_cap / 24'h00_0064);
    end

    // offsets captured while sleep is due, in the same cycle the sleep flag rises
    if (sleep_due && !s_q.sleeping) begin
      s_d.counter_offset  = cal_offsets.counter_offset;
      s_d.gnd_offset = cal_offsets.gnd_offset;
      s_d.adc_offset = cal_offsets.adc_offset;
      s_d.sleeping   = 1'b1;
    end else if (!sleep_due) begin
      s_d.sleeping = 1'b0;
    end

    // waits for the bit: it resets clear and is only written after reset
    if (!s_q.once_done && s_q.gauge_opt[gauge_cfg_pkg::GA_SINGLE_MIDRANGE_CORRECTION]) begin
      s_d.once_done  = 1'b1;
      s_d.once_pulse = 1'b1;
    end

    // set wins: flag stays until reset
    if (fe_link_error && s_q.misc_high[gauge_cfg_pkg::MH_FE_CHECK] &&
        s_q.ctl[gauge_cfg_pkg::CT_FE_PF_EN]) begin
      s_d.fe_fail = 1'b1;
    end

    s_d.ctrl.led_relative  = s_q.pack_opt[gauge_cfg_pkg::PK_LED_SRC];
    s_d.ctrl.led_segments  =
      led_count(s_q.pack_opt[gauge_cfg_pkg::PK_LED_CNT +: 2]);
    s_d.ctrl.host_pec      = s_q.pack_opt[gauge_cfg_pkg::PK_HOST_PEC];
    s_d.ctrl.charger_pec   = s_q.pack_opt[gauge_cfg_pkg::PK_CHG_PEC];
    // mode requests cannot override the disable
    s_d.ctrl.host_bcast_en = mode_bcast_request &&
      !s_q.pack_opt[gauge_cfg_pkg::PK_BC_DIS];
    s_d.ctrl.charger_bcast_en = !s_q.pack_opt[gauge_cfg_pkg::PK_BC_DIS];
    s_d.ctrl.cell_count    =
      cell_count(s_q.pack_opt[gauge_cfg_pkg::PK_CELLS +: 2]);
    s_d.ctrl.indep_learning = s_q.gauge_opt[gauge_cfg_pkg::GA_INDEP_CHG];
    s_d.ctrl.edv_comp      = s_q.gauge_opt[gauge_cfg_pkg::GA_EDV_COMP];
    s_d.ctrl.edv_from_pack = s_q.gauge_opt[gauge_cfg_pkg::GA_EDV_SRC];
    s_d.ctrl.ov_from_cells = s_q.gauge_opt[gauge_cfg_pkg::GA_OV_SRC];
    s_d.ctrl.continuous_midrange_correction_enable   = s_q.gauge_opt[gauge_cfg_pkg::GA_CONTINUOUS_MIDRANGE_CORRECTION];
    s_d.ctrl.int_temp      = s_q.misc_high[gauge_cfg_pkg::MH_INT_TEMP];
    s_d.ctrl.fe_check      = s_q.misc_high[gauge_cfg_pkg::MH_FE_CHECK];
    s_d.ctrl.fe_pf_enable  = s_q.ctl[gauge_cfg_pkg::CT_FE_PF_EN];
    s_d.ctrl.charge_fet_off    = overtemp;
    s_d.ctrl.discharge_fet_off = overtemp &&
      s_q.misc_high[gauge_cfg_pkg::MH_OT_DSG];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q           <= '0;
      s_q.pack_opt  <= gauge_cfg_pkg::RST_PACK_OPT;
      s_q.gauge_opt <= gauge_cfg_pkg::RST_GAUGE_OPT;
      s_q.misc_high <= gauge_cfg_pkg::RST_MISC_HIGH;
      s_q.effic     <= gauge_cfg_pkg::RST_EFFIC;
      s_q.term_pct  <= gauge_cfg_pkg::RST_TERM_PCT;
      s_q.cycle_count <= gauge_cfg_pkg::RST_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata              = s_q.rdata;
  assign ctrl               = s_q.ctrl;
  assign charge_delta       = s_q.delta;
  assign charge_delta_valid = s_q.delta_valid;
  assign sleep_now          = s_q.sleeping;
  assign midrange_once      = s_q.once_pulse;
  assign fe_perm_fail       = s_q.fe_fail;
endmodule

// ===== dv/smbus_far_side.sv
// far-side bus parties: host and charger idling or holding the lines low
`timescale 1ns/10ps
module smbus_far_side (
  input  wire logic hold_low,
  output logic      clk_line,
  output logic      data_line
);
  // lines have pull-ups: released means high, never a stale value
  assign clk_line  = hold_low ? 1'b0 : 1'b1;
  assign data_line = hold_low ? 1'b0 : 1'b1;
endmodule

// ===== dv/gauge_config_decode_asserts.sv
// port-level checker for the configuration decoder
`timescale 1ns/10ps
module gauge_config_decode_asserts (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire gauge_cfg_pkg::reg_req_t    req,
  input wire logic [15:0]                rdata,
  input wire logic                       smbus_clk_pin,
  input wire logic                       smbus_data_pin,
  input wire logic                       conv_valid,
  input wire logic                       overtemp,
  input wire logic                       mode_bcast_request,
  input wire gauge_cfg_pkg::gauge_ctrl_t ctrl,
  input wire logic                       charge_delta_valid,
  input wire logic                       sleep_now,
  input wire logic                       midrange_once,
  input wire logic                       fe_perm_fail
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  AST_BCAST_PAIR: assert property (
    ctrl.host_bcast_en |-> ctrl.charger_bcast_en)
    else $error("host broadcast on while broadcasts disabled");
  AST_HOST_BCAST: assert property (
    ctrl.host_bcast_en |-> $past(mode_bcast_request))
    else $error("host broadcast without mode request");
  AST_OT_CHARGE: assert property (
    $past(overtemp) |-> ctrl.charge_fet_off)
    else $error("charge switch left on in overtemperature");
  AST_OT_DSG: assert property (
    ctrl.discharge_fet_off |-> $past(overtemp))
    else $error("discharge switch off without overtemperature");
  AST_DELTA_CAUSE: assert property (
    charge_delta_valid |-> $past(conv_valid))
    else $error("charge result without conversion");
  // pins reach the idle timer through two sync stages and its own register
  AST_SLEEP_BUS: assert property (
    $rose(sleep_now) |->
      !$past(smbus_clk_pin, 3) && !$past(smbus_data_pin, 3))
    else $error("sleep entered while bus not low");
  AST_FE_STICKY: assert property (fe_perm_fail |=> fe_perm_fail)
    else $error("front-end failure flag dropped");
  AST_ONCE_PULSE: assert property (midrange_once |=> !midrange_once)
    else $error("one-time correction pulse too long");
endmodule

// ===== dv/gauge_config_decode_tb.sv
// register-level regression for the configuration decoder
`timescale 1ns/10ps
module gauge_config_decode_tb;
  logic                       clk, rst, hold_low, conv_valid, conv_discharge;
  logic                       charge_term, overtemp, fe_link_error, mode_req;
  logic                       sclk, sdat, delta_valid, sleep_now, once, fe_pf;
  logic [15:0]                conv_result, rdata;
  logic [31:0]                charge_delta;
  gauge_cfg_pkg::reg_req_t    req;
  gauge_cfg_pkg::gauge_ctrl_t ctrl;
  gauge_cfg_pkg::offset_set_t offs;
  int                         failures, check_count, i, once_n;
  logic [7:0]                 pk;
  logic [2:0]                 seg_exp [4] = '{3'h5, 3'h3, 3'h4, 3'h5};
  logic [7:0]                 rst_ofs [6] = '{8'h28, 8'h29, 8'h2A, 8'h54, 8'hE5, 8'h00};
  logic [15:0]                rst_val [6] = '{16'h0063, 16'h0040, 16'h0002,
                                             16'h00FF, 16'h0064, 16'h0000};

  // short idle count keeps the sleep scenario within a few hundred cycles
  gauge_config_decode #(.SLEEP_IDLE_CYCLES(20)) dut (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .smbus_clk_pin(sclk),
    .smbus_data_pin(sdat), .conv_result(conv_result), .conv_valid(conv_valid),
    .conv_discharge(conv_discharge), .charge_term(charge_term),
    .overtemp(overtemp), .fe_link_error(fe_link_error),
    .mode_bcast_request(mode_req), .cal_offsets(offs), .ctrl(ctrl),
    .charge_delta(charge_delta), .charge_delta_valid(delta_valid),
    .sleep_now(sleep_now), .midrange_once(once), .fe_perm_fail(fe_pf));
  smbus_far_side far (.hold_low(hold_low), .clk_line(sclk), .data_line(sdat));

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // the one-shot stands a single cycle, so it is counted, not sampled
  always @(posedge clk) begin
    if (once === 1'b1) once_n <= once_n + 1;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic conv(input logic [15:0] v, input logic dsg, input logic [31:0] exp);
    int n;
    @(posedge clk);
    conv_result <= v;
    conv_discharge <= dsg;
    conv_valid <= 1'b1;
    @(posedge clk);
    conv_valid <= 1'b0;
    #1;
    for (n = 0; n < 8 && delta_valid !== 1'b1; n++) #50;
    if (n == 8) begin
      failures++;
      tally_and_finish();
    end
    check(charge_delta, exp);
  endtask
  // one-cycle event: charge termination when term is set, else link error
  task automatic pulse(input logic term);
    @(posedge clk);
    if (term) begin
      charge_term <= 1'b1;
    end else begin
      fe_link_error <= 1'b1;
    end
    @(posedge clk);
    charge_term <= 1'b0;
    fe_link_error <= 1'b0;
    settle();
  endtask

  initial begin
    {hold_low, conv_valid, conv_discharge, charge_term} = '0;
    {overtemp, fe_link_error, failures, check_count} = '0;
    mode_req = 1'b1;
    conv_result = 16'h0000;
    req = '0;
    offs = '{counter_offset: 16'h1234, gnd_offset: 8'h56, adc_offset: 8'h78};
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) rd(rst_ofs[i], rst_val[i]);
    wr(8'h90, 16'hBEEF);
    rd(8'h90, 16'h0000);
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      pk = {i[0], i[1:0], i[0], ~i[0], i[1], (i == 0) ? 2'b11 : i[1:0]};
      @(posedge clk);
      mode_req <= i[0];
      wr(8'h28, {8'h00, pk});
      settle();
      check(ctrl.led_relative, pk[7]);
      check(ctrl.led_segments, seg_exp[i]);
      check({ctrl.host_pec, ctrl.charger_pec}, pk[4:3]);
      check({ctrl.host_bcast_en, ctrl.charger_bcast_en},
            {~pk[2] & i[0], ~pk[2]});
      check(ctrl.cell_count, pk[1:0] + 3'h1);
    end
    $display("test pack options done");
    for (i = 0; i < 2; i++) begin
      pk = i ? 8'h15 : 8'h2A;
      wr(8'h29, {8'h00, pk});
      settle();
      check({ctrl.indep_learning, ctrl.edv_comp}, pk[5:4]);
      check({ctrl.edv_from_pack, ctrl.ov_from_cells}, pk[3:2]);
      check(ctrl.continuous_midrange_correction_enable, pk[1]);
    end
    overtemp <= 1'b1;
    for (i = 0; i < 2; i++) begin
      pk = i ? 8'h12 : 8'hAA;
      wr(8'h2A, {8'h00, pk});
      settle();
      check(ctrl.int_temp, pk[7]);
      check(ctrl.fe_check, pk[5]);
      check({ctrl.charge_fet_off, ctrl.discharge_fet_off}, {1'b1, pk[3]});
    end
    overtemp <= 1'b0;
    check(once_n, 32'h1);
    $display("test gauge and misc options done");
    wr(8'h2A, 16'h00A2);
    pulse(1'b0);
    check(fe_pf, 1'b0);
    wr(8'hE0, 16'h0002);
    pulse(1'b0);
    check(fe_pf, 1'b1);
    wr(8'h32, 16'd1000);
    wr(8'h04, 16'd10800);
    rd(8'hE3, 16'd1000);
    wr(8'hE0, 16'h0003);
    rd(8'hE3, 16'd1080);
    wr(8'h2C, 16'h0010);
    rd(8'hE6, 16'h1220);
    rd(8'hE7, 16'h0000);
    wr(8'h02, 16'h0120);
    rd(8'h02, 16'h0120);
    $display("test capacity and filter done");
    wr(8'hCB, 16'h0002);
    wr(8'hCD, 16'h0000);
    wr(8'hCE, 16'h0001);
    wr(8'h37, 16'h0300);
    conv(16'h0100, 1'b1, 32'h0000_0200);
    rd(8'hE2, 16'h0000);
    conv(16'h0100, 1'b1, 32'h0000_0200);
    rd(8'hE2, 16'h0001);
    wr(8'h54, 16'h007F);
    conv(16'h0100, 1'b0, 32'h0000_0100);
    wr(8'h36, 16'd1000);
    wr(8'h29, 16'h0040);
    pulse(1'b1);
    rd(8'hE4, 16'd1000);
    wr(8'h29, 16'h0000);
    wr(8'hE4, 16'h0005);
    pulse(1'b1);
    rd(8'hE4, 16'h0005);
    $display("test charge counting done");
    wr(8'h2A, 16'h0012);
    hold_low <= 1'b1;
    repeat (40) @(posedge clk);
    #1 check(sleep_now, 1'b0);
    wr(8'h2A, 16'h0002);
    for (i = 0; i < 100 && sleep_now !== 1'b1; i++) @(posedge clk);
    if (i == 100) begin
      failures++;
      tally_and_finish();
    end
    rd(8'hD2, 16'h1234);
    rd(8'hD4, 16'h0056);
    rd(8'hD5, 16'h0078);
    hold_low <= 1'b0;
    $display("test sleep and offsets done");
    tally_and_finish();
  end
endmodule

bind gauge_config_decode gauge_config_decode_asserts chk (
  .clk(clk), .rst(rst), .req(req), .rdata(rdata),
  .smbus_clk_pin(smbus_clk_pin), .smbus_data_pin(smbus_data_pin),
  .conv_valid(conv_valid), .overtemp(overtemp),
  .mode_bcast_request(mode_bcast_request), .ctrl(ctrl),
  .charge_delta_valid(charge_delta_valid), .sleep_now(sleep_now),
  .midrange_once(midrange_once), .fe_perm_fail(fe_perm_fail));
